// ---- design/tlbctl_top.sv ----
`include "tlbctl_params.svh"
module tlbctl_top
	import tlbctl_pkg::*;
(
	input  wire logic                        core_clk,    // core clock, 50 MHz
	input  wire logic                        rst_n,       // async reset, active low
	input  wire logic                        cmd_valid,   // coprocessor command strobe
	input  wire tlbctl_pkg::tlbctl_cmd_e     cmd,         // command code
	input  wire logic                        cmd_dside,   // 1 data TLB, 0 instruction TLB
	input  wire logic [`TLBCTL_VPN_W-1:0]    cmd_vpn,     // command virtual page
	output logic                             cmd_busy,    // walk in progress, lock or miss
	input  wire logic                        ctrl_wr,     // control register write strobe
	input  wire logic [31:0]                 ctrl_wdata,  // control register write data
	input  wire logic                        sync_wait,   // coprocessor_sync_wait done
	output logic                             mmu_on,      // translation enabled
	input  wire logic                        i_req,       // instruction lookup request
	input  wire logic [`TLBCTL_VPN_W-1:0]    i_vpn,       // instruction virtual page
	output logic                             i_hit,       // instruction lookup ready
	output logic      [`TLBCTL_PFN_W-1:0]    i_pfn,       // instruction physical page
	output logic                             i_cacheable, // fetch cacheable
	input  wire logic                        d_req,       // data lookup request
	input  wire logic [`TLBCTL_VPN_W-1:0]    d_vpn,       // data virtual page
	output logic                             d_hit,       // data lookup ready
	output logic      [`TLBCTL_PFN_W-1:0]    d_pfn,       // data physical page
	output logic                             d_cacheable, // data cacheable
	output logic                             walk_req,    // table walk request
	output logic      [`TLBCTL_VPN_W-1:0]    walk_vpn,    // page to walk
	input  wire logic                        walk_done,   // walk finished pulse
	input  wire logic                        walk_abort,  // walk finished with abort
	input  wire logic [`TLBCTL_PFN_W-1:0]    walk_pfn,    // walk physical page
	input  wire logic [`TLBCTL_ATTR_W-1:0]   walk_attr,   // walk attributes, bit 0 cacheable
	output logic                             lock_abort,  // fault status lock-abort flag
	output logic                             data_abort   // data abort pulse
);
	import tlbctl_pkg::*;

	typedef struct packed {
		tlbctl_state_e                 state;
		logic                          mmu_en;
		logic                          mmu_pend;
		logic                          w_lock;
		logic                          w_dside;
		logic [`TLBCTL_VPN_W-1:0]      w_vpn;
		logic                          lock_abort;
		logic                          dabort;
	} tlbctl_top_s;
	tlbctl_top_s st_r;
	tlbctl_top_s st_nxt;

	logic                        i_tlb_hit;
	logic                        d_tlb_hit;
	logic [`TLBCTL_PFN_W-1:0]    i_tlb_pfn;
	logic [`TLBCTL_PFN_W-1:0]    d_tlb_pfn;
	logic [`TLBCTL_ATTR_W-1:0]   i_tlb_attr;
	logic [`TLBCTL_ATTR_W-1:0]   d_tlb_attr;
	logic                        cmd_go;
	logic                        fill_i;
	logic                        fill_d;
	logic                        inv_all_i;
	logic                        inv_all_d;
	logic                        inv_ent_i;
	logic                        inv_ent_d;
	logic                        unl_i;
	logic                        unl_d;
	logic [`TLBCTL_VPN_W-1:0]    i_key;
	logic [`TLBCTL_VPN_W-1:0]    d_key;

	// ****************************************
	// command decode
	// ****************************************
	assign cmd_go    = cmd_valid && st_r.state == TLBCTL_ST_IDLE;
	assign inv_all_i = cmd_go && (cmd == TLBCTL_CMD_INV_ALL
		|| (cmd == TLBCTL_CMD_INV_ONE && !cmd_dside));
	assign inv_all_d = cmd_go && (cmd == TLBCTL_CMD_INV_ALL
		|| (cmd == TLBCTL_CMD_INV_ONE && cmd_dside));
	assign inv_ent_i = cmd_go && cmd == TLBCTL_CMD_INV_ENT && !cmd_dside;
	assign inv_ent_d = cmd_go && cmd == TLBCTL_CMD_INV_ENT && cmd_dside;
	assign unl_i     = cmd_go && cmd == TLBCTL_CMD_UNLOCK && !cmd_dside;
	assign unl_d     = cmd_go && cmd == TLBCTL_CMD_UNLOCK && cmd_dside;
	assign cmd_busy  = st_r.state != TLBCTL_ST_IDLE;

	// fill happens when the walk returns without abort
	assign fill_i = st_r.state == TLBCTL_ST_WALK && walk_done && !walk_abort && !st_r.w_dside;
	assign fill_d = st_r.state == TLBCTL_ST_WALK && walk_done && !walk_abort && st_r.w_dside;

	// lookup key: command address for invalidate, walk address while walking
	always_comb begin
		i_key = i_vpn;
		d_key = d_vpn;
		if (cmd_go) begin
			i_key = cmd_vpn;
			d_key = cmd_vpn;
		end else if (st_r.state == TLBCTL_ST_WALK) begin
			i_key = st_r.w_vpn;
			d_key = st_r.w_vpn;
		end
	end

	// ****************************************
	// the two buffers
	// ****************************************
	tlbctl_tlb u_itlb (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.inv_all   (inv_all_i),
		.inv_ent   (inv_ent_i),
		.unlock    (unl_i),
		.fill      (fill_i),
		.fill_lock (st_r.w_lock),
		.vpn       (i_key),
		.fill_pfn  (walk_pfn),
		.fill_attr (walk_attr),
		.hit       (i_tlb_hit),
		.hit_pfn   (i_tlb_pfn),
		.hit_attr  (i_tlb_attr),
		.rr_ptr    (),
		.lock_ptr  ()
	);
	tlbctl_tlb u_dtlb (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.inv_all   (inv_all_d),
		.inv_ent   (inv_ent_d),
		.unlock    (unl_d),
		.fill      (fill_d),
		.fill_lock (st_r.w_lock),
		.vpn       (d_key),
		.fill_pfn  (walk_pfn),
		.fill_attr (walk_attr),
		.hit       (d_tlb_hit),
		.hit_pfn   (d_tlb_pfn),
		.hit_attr  (d_tlb_attr),
		.rr_ptr    (),
		.lock_ptr  ()
	);

	// ****************************************
	// lookup answers
	// ****************************************
	always_comb begin
		if (!st_r.mmu_en) begin
			i_hit = i_req; // flat mapping while off
			i_pfn = i_vpn;
			i_cacheable = 1'b1;
			d_hit = d_req;
			d_pfn = d_vpn;
			d_cacheable = 1'b0;
		end else begin
			i_hit = i_req && i_tlb_hit && st_r.state == TLBCTL_ST_IDLE && !cmd_go;
			i_pfn = i_tlb_pfn;
			i_cacheable = i_tlb_attr[0];
			d_hit = d_req && d_tlb_hit && st_r.state == TLBCTL_ST_IDLE && !cmd_go;
			d_pfn = d_tlb_pfn;
			d_cacheable = d_tlb_attr[0];
		end
	end

	assign walk_req   = st_r.state == TLBCTL_ST_WALK;
	assign walk_vpn   = st_r.w_vpn;
	assign mmu_on     = st_r.mmu_en;
	assign lock_abort = st_r.lock_abort;
	assign data_abort = st_r.dabort;

	// ****************************************
	// control, walk sequencing, abort flags
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.dabort = 1'b0;
		if (sync_wait || (st_r.mmu_pend && st_r.state == TLBCTL_ST_IDLE)) begin
			st_nxt.mmu_en = st_r.mmu_pend;
		end
		// a disable write comes last so a still pending enable cannot override it
		if (ctrl_wr) begin
			st_nxt.mmu_pend = ctrl_wdata[`TLBCTL_CTRL_MMU_EN];
			if (!ctrl_wdata[`TLBCTL_CTRL_MMU_EN]) begin
				st_nxt.mmu_en = 1'b0;
			end
		end
		case (st_r.state)
			TLBCTL_ST_IDLE: begin
				if (cmd_go && cmd == TLBCTL_CMD_LOCK) begin
					st_nxt.state = TLBCTL_ST_WALK;
					st_nxt.w_lock = 1'b1;
					st_nxt.w_dside = cmd_dside;
					st_nxt.w_vpn = cmd_vpn;
				end else if (!cmd_go && st_r.mmu_en && i_req && !i_tlb_hit) begin
					st_nxt.state = TLBCTL_ST_WALK;
					st_nxt.w_lock = 1'b0;
					st_nxt.w_dside = 1'b0;
					st_nxt.w_vpn = i_vpn;
				end else if (!cmd_go && st_r.mmu_en && d_req && !d_tlb_hit) begin
					st_nxt.state = TLBCTL_ST_WALK;
					st_nxt.w_lock = 1'b0;
					st_nxt.w_dside = 1'b1;
					st_nxt.w_vpn = d_vpn;
				end
			end
			TLBCTL_ST_WALK: begin
				if (walk_done) begin
					st_nxt.state = TLBCTL_ST_IDLE;
					st_nxt.w_lock = 1'b0;
					if (walk_abort && st_r.w_lock) begin
						st_nxt.lock_abort = 1'b1;
						st_nxt.dabort = 1'b1;
					end else if (walk_abort) begin
						st_nxt.lock_abort = 1'b0;
						st_nxt.dabort = st_r.w_dside;
					end
				end
			end
			default: begin
				st_nxt.state = TLBCTL_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_MMU_AFTER_SYNC: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_wr && ctrl_wdata[0] ##1 (!ctrl_wr) [*1] ##0 sync_wait |=> mmu_on)
		else $error("translation not on after sync wait");
	AST_OFF_ATTRS: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mmu_on |-> i_cacheable && !d_cacheable)
		else $error("attributes wrong while translation off");
	AST_LOCK_ABORT: assert property (@(posedge core_clk) disable iff (!rst_n)
		walk_req && st_r.w_lock && walk_done && walk_abort |=> lock_abort && data_abort)
		else $error("lock abort not reported");
	AST_MISS_WALK: assert property (@(posedge core_clk) disable iff (!rst_n)
		mmu_on && !cmd_busy && !cmd_valid && d_req && !i_req && !d_tlb_hit |=> walk_req)
		else $error("miss did not start a walk");
	// a disable write must act on the very next edge
	AST_DISABLE_NOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_wr && !ctrl_wdata[0] |=> !mmu_on)
		else $error("translation still on after disable write");
	// flat mapping while translation is off
	AST_OFF_FLAT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mmu_on |-> i_pfn == i_vpn && d_pfn == d_vpn)
		else $error("address not passed through while translation off");
	// a lock command starts a walk of its own page
	AST_LOCK_WALK: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_valid && !cmd_busy && cmd == TLBCTL_CMD_LOCK |=> walk_req
			&& walk_vpn == $past(cmd_vpn))
		else $error("lock command did not start a walk");
	// no translated lookup answers while a walk owns the buffers; flat answers go on while translation is off
	AST_BUSY_NO_HIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		mmu_on && cmd_busy |-> !i_hit && !d_hit)
		else $error("lookup answered during a walk");
	// the abort is a single-cycle pulse
	AST_ABORT_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		data_abort |=> !data_abort)
		else $error("data abort held longer than one cycle");
endmodule // tlbctl_top

// ---- inc/tlbctl_params.svh ----
`ifndef TLBCTL_PARAMS_SVH
`define TLBCTL_PARAMS_SVH
// ****************************************
// entry layout and reset values
// ****************************************
`define TLBCTL_ENTRIES     32
`define TLBCTL_IDX_W       5
`define TLBCTL_TOP_IDX     5'h1F
`define TLBCTL_LOCK_MAX    5'h1E
`define TLBCTL_RR_RST      5'h1F
`define TLBCTL_LP_RST      5'h00
`define TLBCTL_CTRL_MMU_EN 0
`define TLBCTL_VPN_W       20
`define TLBCTL_PFN_W       20
`define TLBCTL_ATTR_W      8
`endif

// ---- inc/tlbctl_pkg.sv ----
`include "tlbctl_params.svh"
package tlbctl_pkg;
	// ****************************************
	// command codes and walk states
	// ****************************************
	typedef enum logic [2:0] {
		TLBCTL_CMD_NONE   = 3'h0,
		TLBCTL_CMD_INV_ALL = 3'h1,
		TLBCTL_CMD_INV_ONE = 3'h2,
		TLBCTL_CMD_INV_ENT = 3'h3,
		TLBCTL_CMD_LOCK    = 3'h4,
		TLBCTL_CMD_UNLOCK  = 3'h5
	} tlbctl_cmd_e;
	typedef enum logic [1:0] {
		TLBCTL_ST_IDLE = 2'h0,
		TLBCTL_ST_WALK = 2'h1
	} tlbctl_state_e;
endpackage

// ---- design/tlbctl_tlb.sv ----
`include "tlbctl_params.svh"
// one translation buffer: entries, lookup, round-robin and lock pointers
module tlbctl_tlb (
	input  wire logic                        core_clk,   // core clock
	input  wire logic                        rst_n,      // async reset, active low
	input  wire logic                        inv_all,    // global invalidate pulse
	input  wire logic                        inv_ent,    // per-entry invalidate pulse
	input  wire logic                        unlock,     // unlock all pulse
	input  wire logic                        fill,       // write walk result pulse
	input  wire logic                        fill_lock,  // fill is a lock operation
	input  wire logic [`TLBCTL_VPN_W-1:0]    vpn,        // virtual page number
	input  wire logic [`TLBCTL_PFN_W-1:0]    fill_pfn,   // walk physical page
	input  wire logic [`TLBCTL_ATTR_W-1:0]   fill_attr,  // walk attributes
	output logic                             hit,        // lookup hit
	output logic      [`TLBCTL_PFN_W-1:0]    hit_pfn,    // hit physical page
	output logic      [`TLBCTL_ATTR_W-1:0]   hit_attr,   // hit attributes
	output logic      [`TLBCTL_IDX_W-1:0]    rr_ptr,     // round-robin pointer
	output logic      [`TLBCTL_IDX_W-1:0]    lock_ptr    // lock pointer
);
	localparam int N = `TLBCTL_ENTRIES;
	typedef struct packed {
		logic [N-1:0]                          valid;
		logic [N-1:0]                          locked;
		logic [N-1:0]                          hole;
		logic [N-1:0][`TLBCTL_VPN_W-1:0]       vpn;
		logic [N-1:0][`TLBCTL_PFN_W-1:0]       pfn;
		logic [N-1:0][`TLBCTL_ATTR_W-1:0]      attr;
		logic [`TLBCTL_IDX_W-1:0]              rr;
		logic [`TLBCTL_IDX_W-1:0]              lp;
	} tlbctl_tlb_s;
	tlbctl_tlb_s st_r;
	tlbctl_tlb_s st_nxt;
	logic [`TLBCTL_IDX_W-1:0] hit_idx;
	logic [`TLBCTL_IDX_W-1:0] first_free;
	logic [`TLBCTL_IDX_W-1:0] wr_idx;

	// ****************************************
	// lookup: valid, non-hole, matching only
	// ****************************************
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = 0; i < N; i++) begin
			if (st_r.valid[i] && !st_r.hole[i] && st_r.vpn[i] == vpn && !hit) begin
				hit = 1'b1;
				hit_idx = i[`TLBCTL_IDX_W-1:0];
			end
		end
		hit_pfn = st_r.pfn[hit_idx];
		hit_attr = st_r.attr[hit_idx];
	end

	// first entry not locked, target of wrap from the top
	always_comb begin
		first_free = `TLBCTL_TOP_IDX;
		for (int i = N - 1; i >= 0; i--) begin
			if (!st_r.locked[i]) begin
				first_free = i[`TLBCTL_IDX_W-1:0];
			end
		end
	end

	assign wr_idx = fill_lock ? st_r.lp : st_r.rr;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		if (inv_all) begin
			st_nxt.valid = st_r.valid & st_r.locked;
		end
		if (inv_ent && hit) begin
			if (st_r.locked[hit_idx]) begin
				st_nxt.hole[hit_idx] = 1'b1;
			end else begin
				st_nxt.valid[hit_idx] = 1'b0;
			end
		end
		if (unlock) begin
			st_nxt.locked = '0;
			st_nxt.hole = '0;
			st_nxt.lp = `TLBCTL_LP_RST;
		end
		if (fill) begin
			st_nxt.valid[wr_idx] = 1'b1;
			st_nxt.hole[wr_idx] = 1'b0;
			st_nxt.vpn[wr_idx] = vpn;
			st_nxt.pfn[wr_idx] = fill_pfn;
			st_nxt.attr[wr_idx] = fill_attr;
			if (fill_lock) begin
				if (st_r.lp <= `TLBCTL_LOCK_MAX) begin
					st_nxt.locked[wr_idx] = 1'b1;
					st_nxt.lp = st_r.lp + 5'h01;
				end
				st_nxt.rr = `TLBCTL_TOP_IDX;
			end else if (st_r.rr == `TLBCTL_TOP_IDX) begin
				st_nxt.rr = first_free;
			end else begin
				st_nxt.rr = st_r.rr + 5'h01;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.rr <= `TLBCTL_RR_RST;
			st_r.lp <= `TLBCTL_LP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rr_ptr = st_r.rr;
	assign lock_ptr = st_r.lp;

	// ****************************************
	// checks
	// ****************************************
	AST_RR_RESET_TOP: assert property (@(posedge core_clk) $rose(rst_n) |-> rr_ptr == 5'h1F)
		else $error("round-robin pointer not at top after reset");
	AST_TOP_NEVER_LOCKED: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st_r.locked[N-1])
		else $error("top entry became locked");
	AST_LOCK_RR_TOP: assert property (@(posedge core_clk) disable iff (!rst_n)
		fill && fill_lock |=> rr_ptr == 5'h1F)
		else $error("lock did not reset round-robin pointer");
	AST_LOCK_PTR_ADV: assert property (@(posedge core_clk) disable iff (!rst_n)
		fill && fill_lock && !unlock && lock_ptr < 5'h1F |=> lock_ptr == $past(lock_ptr) + 5'h01)
		else $error("lock pointer did not advance");
	AST_LOCK_AT_TOP: assert property (@(posedge core_clk) disable iff (!rst_n)
		fill && fill_lock && !unlock && lock_ptr == 5'h1F |=> lock_ptr == 5'h1F)
		else $error("lock at top moved lock pointer");
	AST_RR_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		fill && !fill_lock && rr_ptr != 5'h1F |=> rr_ptr == $past(rr_ptr) + 5'h01)
		else $error("round-robin pointer did not step");
	AST_RR_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
		fill && !fill_lock && rr_ptr == 5'h1F && st_r.locked == '0 |=> rr_ptr == 5'h00)
		else $error("round-robin pointer did not wrap to zero");
	AST_INV_KEEPS_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
		inv_all && !fill && !unlock |=> (st_r.valid & st_r.locked) == $past(st_r.locked))
		else $error("global invalidate dropped a locked entry");
	AST_LP_RESET: assert property (@(posedge core_clk) $rose(rst_n) |-> lock_ptr == 5'h00)
		else $error("lock pointer not at entry zero after reset");
	AST_INV_ALL_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
		inv_all |=> (st_r.valid & ~st_r.locked) == '0)
		else $error("global invalidate left an unlocked entry valid");
endmodule // tlbctl_tlb

// ---- sim/tlbctl_walker.sv ----
// table walk model: answers each walk after a random delay, junk outside the answer
module tlbctl_walker (
	input  wire logic        core_clk,   // core clock
	input  wire logic        rst_n,      // async reset, active low
	input  wire logic        walk_req,   // walk request level
	input  wire logic [19:0] walk_vpn,   // page to walk
	input  wire logic        abort_en,   // answer next walk with abort
	output logic             walk_done,  // walk finished pulse
	output logic             walk_abort, // abort flag with done
	output logic      [19:0] walk_pfn,   // physical page
	output logic      [7:0]  walk_attr   // attributes, bit 0 cacheable
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned wait_n;
	// idle values at time zero
	initial begin
		walk_done = 1'b0;
		walk_abort = 1'b0;
		walk_pfn = 20'h0;
		walk_attr = 8'h0;
		wait_n = 0;
	end
	// done pulses one cycle; data lines toggle when not qualified so stale values never match
	always @(posedge core_clk) begin
		#1;
		if (walk_done || !walk_req || !rst_n) begin
			walk_done = 1'b0;
			walk_abort = ~walk_abort;
			walk_pfn = ~walk_pfn;
			walk_attr = ~walk_attr;
			wait_n = $urandom_range(3, 0);
		end else if (wait_n != 0) begin
			wait_n--;
		end else begin
			walk_done = 1'b1;
			walk_abort = abort_en;
			walk_pfn = walk_vpn ^ 20'h5A5A5;
			walk_attr = {7'h2A, walk_vpn[0]};
		end
	end
endmodule // tlbctl_walker

// ---- sim/tlbctl_top_tb.sv ----
module tlbctl_top_tb;
	import tlbctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        side;
		logic [22:0] exp;
		logic [22:0] msk;
	} tlbctl_note_s;
	logic core_clk, rst_n, cmd_valid, cmd_dside, cmd_busy, ctrl_wr, sync_wait, mmu_on;
	logic i_req, i_hit, i_cacheable, d_req, d_hit, d_cacheable, walk_req, walk_done;
	logic walk_abort, lock_abort, data_abort, abort_en, probe;
	tlbctl_cmd_e cmd;
	logic [19:0] cmd_vpn, i_vpn, i_pfn, d_vpn, d_pfn, walk_vpn, walk_pfn, bp;
	logic [31:0] ctrl_wdata;
	logic [7:0]  walk_attr;
	tlbctl_note_s lq[$];
	logic [1:0]   aq[$];
	int mismatches, n_checks, cyc;
	tlbctl_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_dside(cmd_dside), .cmd_vpn(cmd_vpn), .cmd_busy(cmd_busy), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .sync_wait(sync_wait), .mmu_on(mmu_on), .i_req(i_req),
		.i_vpn(i_vpn), .i_hit(i_hit), .i_pfn(i_pfn), .i_cacheable(i_cacheable), .d_req(d_req),
		.d_vpn(d_vpn), .d_hit(d_hit), .d_pfn(d_pfn), .d_cacheable(d_cacheable),
		.walk_req(walk_req), .walk_vpn(walk_vpn), .walk_done(walk_done),
		.walk_abort(walk_abort), .walk_pfn(walk_pfn), .walk_attr(walk_attr),
		.lock_abort(lock_abort), .data_abort(data_abort));
	tlbctl_walker walk_u (.core_clk(core_clk), .rst_n(rst_n), .walk_req(walk_req),
		.walk_vpn(walk_vpn), .abort_en(abort_en), .walk_done(walk_done),
		.walk_abort(walk_abort), .walk_pfn(walk_pfn), .walk_attr(walk_attr));
	// ****************************************
	// clock, timeout, compare
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp_look(input logic [22:0] a, input logic [22:0] e);
		n_checks++;
		if (a !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t lookup act=%h exp=%h", $time, a, e);
		end
	endtask
	task automatic cmp_abort(input logic [1:0] a, input logic [1:0] e);
		n_checks++;
		if (a !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t abort act=%h exp=%h", $time, a, e);
		end
	endtask
	// hang guard: far above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			results();
		end
	end
	// monitor: pops the oldest note whenever a lookup or an abort shows
	always @(posedge core_clk) begin
		tlbctl_note_s n;
		logic [22:0] a;
		if (probe) begin
			n = lq.pop_front();
			a = n.side ? {mmu_on, d_hit, d_cacheable, d_pfn} : {mmu_on, i_hit, i_cacheable, i_pfn};
			cmp_look(a & n.msk, n.exp & n.msk);
		end
		if (rst_n && data_abort) begin
			cmp_abort({data_abort, lock_abort}, aq.size() != 0 ? aq.pop_front() : 2'b00);
		end
	end
	// ****************************************
	// drivers
	// ****************************************
	task automatic wait_idle;
		for (int k = 0; k < 100; k++) begin
			if (!cmd_busy && !walk_req) begin
				return;
			end
			@(posedge core_clk);
			#1;
		end
		mismatches++;
		$display("[FAIL] t=%0t idle act=%h exp=%h", $time, 1'b1, 1'b0);
	endtask
	task automatic do_cmd(input tlbctl_cmd_e c, input logic s, input logic [19:0] v);
		cmd_valid = 1'b1;
		cmd = c;
		cmd_dside = s;
		cmd_vpn = v;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		cmd = TLBCTL_CMD_NONE;
		@(posedge core_clk);
		#1;
		wait_idle();
	endtask
	// lookup: side, page, expected mmu_on, hit, cacheable; a miss with mmu on fills
	// with translation off the answer is a flat hit on the page itself
	task automatic look(input logic s, input logic [19:0] v, input logic m, input logic h,
		input logic c);
		lq.push_back('{s, {m, m ? h : 1'b1, c, m ? v ^ 20'h5A5A5 : v},
			{2'b11, m ? h : 1'b1, {20{!m | h}}}});
		d_req = s;
		i_req = !s;
		d_vpn = v;
		i_vpn = v;
		probe = 1'b1;
		@(posedge core_clk);
		#1;
		d_req = 1'b0;
		i_req = 1'b0;
		probe = 1'b0;
		wait_idle();
	endtask
	task automatic ctrl(input logic en);
		ctrl_wr = 1'b1;
		ctrl_wdata = {31'h0, en};
		@(posedge core_clk);
		#1;
		ctrl_wr = 1'b0;
		sync_wait = 1'b1;
		@(posedge core_clk);
		#1;
		sync_wait = 1'b0;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_n, cmd_valid, cmd_dside, ctrl_wr, sync_wait, i_req, d_req, abort_en, probe} = '0;
		{cmd_vpn, i_vpn, d_vpn, ctrl_wdata} = '0;
		cmd = TLBCTL_CMD_NONE;
		void'($urandom(7572));
		bp = 20'($urandom());
		repeat (4) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		look(1'b1, bp, 1'b0, 1'b0, 1'b0);
		look(1'b0, bp, 1'b0, 1'b0, 1'b1);
		ctrl(1'b1);
		look(1'b1, bp, 1'b1, 1'b0, 1'b0);
		$display("test reset_enable done");
		do_cmd(TLBCTL_CMD_INV_ENT, 1'b1, bp + 20'h10);
		do_cmd(TLBCTL_CMD_LOCK, 1'b1, bp + 20'h10);
		look(1'b1, bp + 20'h10, 1'b1, 1'b1, bp[0]);
		do_cmd(TLBCTL_CMD_INV_ENT, 1'b0, bp + 20'h11);
		do_cmd(TLBCTL_CMD_LOCK, 1'b0, bp + 20'h11);
		look(1'b0, bp + 20'h11, 1'b1, 1'b1, !bp[0]);
		aq.push_back(2'b11);
		abort_en = 1'b1;
		do_cmd(TLBCTL_CMD_LOCK, 1'b0, bp + 20'h12);
		abort_en = 1'b0;
		$display("test lock_abort done");
		for (int k = 0; k < 32; k++) begin
			look(1'b1, bp + 20'h100 + 20'(k), 1'b1, 1'b0, 1'b0);
		end
		look(1'b1, bp + 20'h101, 1'b1, 1'b1, !bp[0]);
		look(1'b1, bp + 20'h11F, 1'b1, 1'b1, !bp[0]);
		look(1'b1, bp + 20'h10, 1'b1, 1'b1, bp[0]);
		look(1'b1, bp + 20'h100, 1'b1, 1'b0, 1'b0);
		$display("test round_robin done");
		do_cmd(TLBCTL_CMD_INV_ONE, 1'b1, 20'h0);
		look(1'b1, bp + 20'h10, 1'b1, 1'b1, bp[0]);
		look(1'b1, bp + 20'h105, 1'b1, 1'b0, 1'b0);
		do_cmd(TLBCTL_CMD_INV_ENT, 1'b1, bp + 20'h10);
		look(1'b1, bp + 20'h10, 1'b1, 1'b0, 1'b0);
		do_cmd(TLBCTL_CMD_UNLOCK, 1'b1, 20'h0);
		do_cmd(TLBCTL_CMD_INV_ONE, 1'b1, 20'h0);
		$display("test invalidate done");
		for (int k = 0; k < 32; k++) begin
			do_cmd(TLBCTL_CMD_INV_ENT, 1'b1, bp + 20'h200 + 20'(k));
			do_cmd(TLBCTL_CMD_LOCK, 1'b1, bp + 20'h200 + 20'(k));
		end
		look(1'b1, bp + 20'h21F, 1'b1, 1'b1, !bp[0]);
		do_cmd(TLBCTL_CMD_INV_ONE, 1'b1, 20'h0);
		look(1'b1, bp + 20'h21F, 1'b1, 1'b0, 1'b0);
		look(1'b1, bp + 20'h21E, 1'b1, 1'b1, bp[0]);
		$display("test lock_full done");
		do_cmd(TLBCTL_CMD_INV_ALL, 1'b0, 20'h0);
		look(1'b0, bp + 20'h11, 1'b1, 1'b1, !bp[0]);
		look(1'b1, bp + 20'h200, 1'b1, 1'b1, bp[0]);
		look(1'b1, bp + 20'h21F, 1'b1, 1'b0, 1'b0);
		ctrl(1'b0);
		look(1'b1, bp + 20'h200, 1'b0, 1'b0, 1'b0);
		look(1'b0, bp + 20'h200, 1'b0, 1'b0, 1'b1);
		$display("test global_disable done");
		// mid-run reset: tables, pointers and enable all return to reset state
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		look(1'b1, bp + 20'h200, 1'b0, 1'b0, 1'b0);
		ctrl(1'b1);
		look(1'b1, bp + 20'h200, 1'b1, 1'b0, 1'b0);
		$display("test mid_reset done");
		if (aq.size() != 0) begin
			mismatches++;
		end
		results();
	end
endmodule // tlbctl_top_tb
